// [src/nand_flash_host.sv]
// host controller that sequences nand flash pin-level bus cycles
`timescale 1ns/10ps
module nand_flash_host #(
   parameter int unsigned bus_width = 8,
   parameter int unsigned recovery_count = nand_host_pkg::recovery_cycles,
   parameter int unsigned phase_count = nand_host_pkg::strobe_phase_cycles
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // user request
   input wire logic req_valid,
   input wire nand_host_pkg::req_s req,
   output logic req_ready,
   input wire logic write_enable,
   input wire logic skip_spare,
   // read answer
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   // flash pins
   output nand_host_pkg::pins_s pins,
   output logic [15:0] io_out,
   output logic [15:0] io_oe,
   input wire logic [15:0] io_in,
   input wire logic busy_flag_n,
   // status
   output logic flash_ready
);
   initial begin
      if (bus_width != 8 && bus_width != 16) $error("bus_width must be 8 or 16");
      if (phase_count < 2) $error("phase_count must be at least 2");
      if (phase_count > 65535) $error("phase_count must fit the 16-bit timer");
      if (recovery_count > 65535) $error("recovery_count must fit the 16-bit timer");
      if (nand_host_pkg::addr_cycles < 1 || nand_host_pkg::addr_cycles > 4)
         $error("addr_cycles must fit the 2-bit address counter");
   end

   // ==========================================================
   // sequencer states
   typedef enum logic [5:0] {
      st_power = 6'b00_0001,
      st_idle = 6'b00_0010,
      st_setup = 6'b00_0100,
      st_strobe = 6'b00_1000,
      st_hold = 6'b01_0000,
      st_wait = 6'b10_0000
   } state_e;

   // ==========================================================
   // state and timers
   state_e state_q;
   logic [15:0] timer_q;
   nand_host_pkg::req_s cur_q;
   logic [1:0] addr_idx_q;
   logic rb_sync;
   logic [15:0] io_sync;
   logic busy_n;
   logic timer_done;
   logic addr_open;
   logic rd_sample;

   // ==========================================================
   // input synchronisers
   nand_sync2 #(.width(1)) u_rb_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in(busy_flag_n),
      .sync_out(rb_sync)
   );
   nand_sync2 #(.width(16)) u_io_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in(io_in),
      .sync_out(io_sync)
   );
   assign busy_n = rb_sync;
   assign timer_done = (timer_q == 16'h0000);
   // an address sequence stays open until all of its cycles have been sent or a command, read or write request completes
   assign addr_open = (addr_idx_q != 2'h0);
   // sample at end of low phase, after output access delay
   assign rd_sample = (state_q == st_strobe) && timer_done &&
      (cur_q.op == nand_host_pkg::op_rdata);

   function automatic logic [15:0] lane_mask(input nand_host_pkg::op_e op);
      if (op == nand_host_pkg::op_wdata && bus_width == 16) lane_mask = 16'hffff;
      else lane_mask = 16'h00ff;
   endfunction : lane_mask

   // ==========================================================
   // sequencer
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= st_power;
         timer_q <= 16'(recovery_count);
         cur_q <= '0;
      end else begin
         unique case (state_q)
            st_power: begin
               if (timer_done) state_q <= st_idle;
               else timer_q <= timer_q - 16'h0001;
            end
            st_idle: begin
               if (req_valid) begin
                  cur_q <= req;
                  timer_q <= 16'(phase_count - 1);
                  if (req.op == nand_host_pkg::op_wait_ready) state_q <= st_wait;
                  else state_q <= st_setup;
               end
            end
            st_setup: begin
               if (timer_done) begin
                  timer_q <= 16'(phase_count - 1);
                  state_q <= st_strobe;
               end else timer_q <= timer_q - 16'h0001;
            end
            st_strobe: begin
               if (timer_done) begin
                  timer_q <= 16'(phase_count - 1);
                  state_q <= st_hold;
               end else timer_q <= timer_q - 16'h0001;
            end
            st_hold: begin
               if (timer_done) state_q <= st_idle;
               else timer_q <= timer_q - 16'h0001;
            end
            st_wait: begin
               // busy flag lags the last strobe; the phase delay covers that gap
               if (timer_done) begin
                  if (busy_n) state_q <= st_idle;
               end else timer_q <= timer_q - 16'h0001;
            end
         endcase
      end
   end

   // ==========================================================
   // address cycle count
   always_ff @(posedge mclk) begin
      if (rst) addr_idx_q <= 2'h0;
      else if (state_q == st_hold && timer_done) begin
         if (cur_q.op == nand_host_pkg::op_addr) begin
            if (addr_idx_q == 2'(nand_host_pkg::addr_cycles - 1)) addr_idx_q <= 2'h0;
            else addr_idx_q <= addr_idx_q + 2'h1;
         end else addr_idx_q <= 2'h0;
      end
   end

   // ==========================================================
   // pin drive
   always_ff @(posedge mclk) begin
      if (rst) begin
         pins.chip_select_n <= 1'b1;
         pins.cmd_latch_strobe <= 1'b0;
         pins.addr_latch_strobe <= 1'b0;
         pins.input_strobe_n <= 1'b1;
         pins.output_strobe_n <= 1'b1;
         pins.erase_lockout_n <= 1'b0;
         pins.spare_area_select <= 1'b0;
         io_out <= 16'h0000;
         io_oe <= 16'h0000;
      end else begin
         // lockout stays low through the power wait whatever the user asks
         pins.erase_lockout_n <= (state_q != st_power) && write_enable;
         pins.spare_area_select <= skip_spare;
         // select held low outside power-up, across busy waits too
         pins.chip_select_n <= (state_q == st_power);
         if (state_q == st_idle && req_valid && req.op != nand_host_pkg::op_wait_ready) begin
            pins.cmd_latch_strobe <= (req.op == nand_host_pkg::op_cmd);
            pins.addr_latch_strobe <= (req.op == nand_host_pkg::op_addr);
            if (req.op != nand_host_pkg::op_rdata) begin
               io_out <= req.data & lane_mask(req.op);
               io_oe <= lane_mask(req.op);
            end else io_oe <= 16'h0000;
         end else if (state_q == st_setup && timer_done) begin
            if (cur_q.op == nand_host_pkg::op_rdata) pins.output_strobe_n <= 1'b0;
            else pins.input_strobe_n <= 1'b0;
         end else if (state_q == st_strobe && timer_done) begin
            pins.input_strobe_n <= 1'b1;
            pins.output_strobe_n <= 1'b1;
         end else if (state_q == st_hold && timer_done) begin
            pins.cmd_latch_strobe <= 1'b0;
            pins.addr_latch_strobe <= 1'b0;
            io_oe <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // read capture and handshake outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
         req_ready <= 1'b0;
         flash_ready <= 1'b0;
      end else begin
         rsp_valid <= rd_sample;
         if (rd_sample) rsp_data <= (bus_width == 16) ? io_sync : {8'h00, io_sync[7:0]};
         req_ready <= (state_q == st_idle) && !req_valid;
         // low mid-address too, warning a user off a command on a partial address; req_ready does not block one
         flash_ready <= busy_n && (state_q != st_power) && !addr_open;
      end
   end
endmodule : nand_flash_host

// [src/nand_host_pkg.sv]
// package: pin timing, array geometry and command carrier for the nand host controller
package nand_host_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned clk_period_ns = 10;
   localparam int unsigned recovery_time_ns = 1000;
   localparam int unsigned recovery_cycles = (recovery_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned strobe_phase_cycles = 3;
   // ==========================================================
   // array geometry
   localparam int unsigned pages_per_block = 32;
   localparam int unsigned cells_per_string = 16;
   localparam int unsigned half_page_bytes = 256;
   localparam int unsigned spare_bytes = 16;
   localparam int unsigned main_words = 256;
   localparam int unsigned spare_words = 8;
   localparam int unsigned addr_cycles = 3;
   // ==========================================================
   // request kinds
   typedef enum logic [2:0] {
      op_cmd = 3'h0,
      op_addr = 3'h1,
      op_wdata = 3'h2,
      op_rdata = 3'h3,
      op_wait_ready = 3'h4
   } op_e;
   typedef struct packed {
      op_e op;
      logic [15:0] data;
   } req_s;
   // pin group driven toward the flash
   typedef struct packed {
      logic chip_select_n;
      logic cmd_latch_strobe;
      logic addr_latch_strobe;
      logic input_strobe_n;
      logic output_strobe_n;
      logic erase_lockout_n;
      logic spare_area_select;
   } pins_s;
endpackage : nand_host_pkg

// [src/nand_sync2.sv]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module nand_sync2 #(
   parameter int unsigned width = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // async in, synchronised out
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] meta_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= '1;
         sync_out <= '1;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : nand_sync2

// [bench/nand_flash_host_props.sv]
// assertion checker for the nand host controller pins
`timescale 1ns/10ps
module nand_flash_host_props #(
   parameter int unsigned recovery_count = 4,
   parameter int unsigned phase_count = 3
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // watched ports
   input wire logic write_enable,
   input wire logic skip_spare,
   input wire logic rsp_valid,
   input wire nand_host_pkg::pins_s pins,
   input wire logic [15:0] io_oe,
   input wire logic flash_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   AST_NO_DUAL_LATCH: assert property (pins.cmd_latch_strobe |-> !pins.addr_latch_strobe)
      else $error("both latch strobes high");
   AST_LATCH_SELECTED: assert property (
      (pins.cmd_latch_strobe || pins.addr_latch_strobe) && !pins.input_strobe_n
      |-> !pins.chip_select_n && pins.output_strobe_n) else $error("latch cycle without select");
   AST_CTRL_LANES: assert property ((pins.cmd_latch_strobe || pins.addr_latch_strobe)
      |-> io_oe == 16'h00ff) else $error("control byte not on low lanes");
   AST_STROBE_LOW: assert property ($fell(pins.input_strobe_n)
      |-> !pins.input_strobe_n[*3] ##1 pins.input_strobe_n) else $error("write strobe width");
   AST_POWER_WAIT: assert property ($fell(rst)
      |-> (pins.input_strobe_n && !pins.erase_lockout_n && !flash_ready)[*4])
      else $error("activity inside power wait");
   AST_LOCKOUT: assert property (!write_enable ##1 !write_enable
      |-> !pins.erase_lockout_n) else $error("lockout released while writes disabled");
   AST_SPARE: assert property (skip_spare ##1 skip_spare |-> pins.spare_area_select)
      else $error("spare select not following input");
   AST_READ_ANSWER: assert property ($fell(pins.output_strobe_n) |-> ##[1:10] rsp_valid)
      else $error("no read answer");
   AST_CS_HOLD: assert property (!pins.chip_select_n |=> !pins.chip_select_n)
      else $error("select dropped");
endmodule : nand_flash_host_props
bind nand_flash_host nand_flash_host_props #(.recovery_count(recovery_count),
   .phase_count(phase_count)) u_props (.mclk(mclk), .rst(rst), .write_enable(write_enable),
   .skip_spare(skip_spare), .rsp_valid(rsp_valid), .pins(pins), .io_oe(io_oe),
   .flash_ready(flash_ready));

// [bench/flash_dev_model.sv]
// behavioural nand flash device facing the host controller
`timescale 1ns/10ps
module flash_dev_model #(
   parameter int unsigned bus_width = 8,
   parameter int unsigned output_access_delay = 4,
   parameter int unsigned busy_ns = 300
) (
   // pins from the host
   input wire nand_host_pkg::pins_s pins,
   input wire logic [15:0] bus,
   // answers
   output logic [15:0] dq,
   output logic busy_pull_low
);
   logic [7:0] last_cmd, last_addr, rd;
   logic [15:0] last_data;
   int addr_n = 0, col = 0, page = 0, lim = 0, prog_n = 0, cs_rise_busy = 0;
   initial begin
      dq = 16'h0000;
      busy_pull_low = 0;
   end
   // ==========================================
   // command, address and data capture
   always @(posedge pins.input_strobe_n) begin
      if (!pins.chip_select_n && pins.output_strobe_n) begin
         if (pins.cmd_latch_strobe && !pins.addr_latch_strobe) begin
            last_cmd = bus[7:0];
            addr_n = 0;
            col = 0;
            if (bus[7:0] == 8'h10 && pins.erase_lockout_n) prog_n++;
            if (bus[7:0] == 8'hff) begin
               busy_pull_low = 1;
               #busy_ns busy_pull_low = 0;
            end
         end else if (pins.addr_latch_strobe && !pins.cmd_latch_strobe) begin
            last_addr = bus[7:0];
            addr_n++;
         end else if (!pins.cmd_latch_strobe) last_data = bus;
      end
   end
   // device stays selected while busy; a rise here would abort a row read
   always @(posedge pins.chip_select_n) if (busy_pull_low) cs_rise_busy++;
   // ==========================================
   // read data
   always @(negedge pins.output_strobe_n) begin
      if (!pins.chip_select_n) begin
         rd = 8'(col) ^ 8'h5a;
         col++;
         if (bus_width == 16) lim = nand_host_pkg::main_words;
         else lim = 2 * nand_host_pkg::half_page_bytes;
         if (!pins.spare_area_select) begin
            lim += (bus_width == 16) ? nand_host_pkg::spare_words : nand_host_pkg::spare_bytes;
         end
         if (col == lim) begin
            col = 0;
            page = (page + 1) % nand_host_pkg::pages_per_block;
         end
         #output_access_delay dq = {~rd, rd};
      end
   end
   // released lanes show the inverse, never the last value
   always @(posedge pins.output_strobe_n) dq = ~dq;
endmodule : flash_dev_model

// [bench/testbench.sv]
// self-checking bench for the nand host controller
`timescale 1ns/10ps
module testbench;
   logic mclk = 0, rst = 1, req_valid = 0, write_enable = 0, skip_spare = 0;
   nand_host_pkg::req_s req = '0;
   logic req_ready, rsp_valid, flash_ready, busy_pull_low;
   logic [15:0] rsp_data, io_out, io_oe, dq, got;
   nand_host_pkg::pins_s pins;
   int fail_count = 0, cmp_count = 0, col_m = 0, n;
   integer seed = 32'hf5c7_b293;
   logic [7:0] b;
   logic [15:0] wd;
   wire [15:0] io_in = (io_out & io_oe) | (dq & ~io_oe);
   wire busy_n = !busy_pull_low;
   always #5 mclk = ~mclk;
   nand_flash_host #(.recovery_count(4)) dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .write_enable(write_enable), .skip_spare(skip_spare),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .busy_flag_n(busy_n), .flash_ready(flash_ready));
   flash_dev_model dev (.pins(pins), .bus(io_in), .dq(dq), .busy_pull_low(busy_pull_low));
   // ==========================================
   // shared tasks
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // entered on an edge where the controller was seen idle
   task automatic send(nand_host_pkg::op_e op, logic [15:0] d);
      req_valid <= 1;
      req <= '{op: op, data: d};
      @(posedge mclk);
      req_valid <= 0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 400 && req_ready !== 1'b1; i++) begin
         @(posedge mclk);
         if (rsp_valid === 1'b1) got = rsp_data;
      end
   endtask : send
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // ==========================================
   // tests
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 0;
      for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(posedge mclk);
      chk("flash ready", {15'h0000, flash_ready}, 16'h0001);
      for (int k = 0; k < 4; k++) begin
         b = 8'($random(seed)) & 8'h6e;
         send(nand_host_pkg::op_cmd, {8'ha5, b});
         chk("command", {8'h00, dev.last_cmd}, {8'h00, b});
         for (int a = 0; a < 3; a++) begin
            b = 8'($random(seed));
            send(nand_host_pkg::op_addr, {8'h00, b});
            chk("address", {8'h00, dev.last_addr}, {8'h00, b});
            chk("address done", {15'h0000, flash_ready}, {15'h0000, a == 2});
         end
         chk("address count", 16'(dev.addr_n), 16'h0003);
      end
      $display("test cmd_addr done");
      send(nand_host_pkg::op_cmd, 16'h0000);
      col_m = 0;
      repeat (5) begin
         skip_spare <= 1'($random(seed));
         send(nand_host_pkg::op_rdata, 16'h0000);
         chk("read data", got, {8'h00, 8'(col_m) ^ 8'h5a});
         col_m++;
      end
      $display("test read done");
      for (int w = 0; w < 2; w++) begin
         write_enable <= w[0];
         n = dev.prog_n;
         wd = 16'($random(seed));
         send(nand_host_pkg::op_wdata, wd);
         chk("write data", {8'h00, dev.last_data[7:0]}, {8'h00, wd[7:0]});
         send(nand_host_pkg::op_cmd, 16'h0010);
         chk("program count", 16'(dev.prog_n - n), 16'(w));
      end
      $display("test lockout done");
      send(nand_host_pkg::op_cmd, 16'h00ff);
      send(nand_host_pkg::op_wait_ready, 16'h0000);
      chk("ready after busy", {15'h0000, busy_n}, 16'h0001);
      chk("ready flag", {15'h0000, flash_ready}, 16'h0001);
      chk("select held", 16'(dev.cs_rise_busy), 16'h0000);
      $display("test busy done");
      close_out();
   end
   initial begin
      #40000;
      fail_count++;
      close_out();
   end
endmodule : testbench
